// >>> isrc_pkg.sv
// Package of offsets, bit positions and reset values for the status block
package isrc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PEND_LOW  = 8'h00; // Flags 6..1
  localparam logic [7:0] OFS_PEND_MID  = 8'h04; // Flags 14..7
  localparam logic [7:0] OFS_PEND_HIGH = 8'h08; // Flags 16..15
  localparam logic [7:0] OFS_ENABLE    = 8'h0C; // Source enables
  localparam logic [7:0] OFS_FLAGS     = 8'h10; // Sticky flags, W1C
  localparam logic [7:0] OFS_TIMEBASE  = 8'h14; // Rate and acknowledge

  // ----------------------------------------------------------------
  // Flag and enable bit positions (same index in both registers)
  // ----------------------------------------------------------------
  localparam int F_SRX  = 0;  // Sync receive full / its enable
  localparam int F_STX  = 1;  // Sync transmit empty / its enable
  localparam int F_MODE_FAULT_FLAG = 2;  // Mode fault / sync error enable
  localparam int F_SYNC_OVERFLOW_FLAG = 3;  // Sync overflow / fault detect enable
  localparam int F_ATX  = 4;  // Async transmit empty
  localparam int F_TC   = 5;  // Transmission complete
  localparam int F_ARX  = 6;  // Async receive full
  localparam int F_IDLE = 7;  // Idle input
  localparam int F_OR   = 8;  // Receiver overrun
  localparam int F_NF   = 9;  // Noise
  localparam int F_FE   = 10; // Framing error
  localparam int F_PE   = 11; // Parity error
  localparam int F_KBD  = 12; // Keyboard request
  localparam int F_CONV = 13; // Conversion done
  localparam int F_TB   = 14; // Timebase rollover
  localparam int NFLAG  = 15; // Number of flags

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int TB_ACK_BIT = 3;  // Timebase acknowledge, write only
  localparam int TB_RATE_W  = 3;  // Rate select width
  localparam int TB_BASE    = 8;  // Shortest rollover is 2**TB_BASE
  localparam int IDLE_SHORT = 10; // Ones for idle, 8-bit characters
  localparam int IDLE_LONG  = 11; // Ones for idle, 9-bit characters
  localparam logic [NFLAG-1:0] ENABLE_RST = '0;
  localparam logic [NFLAG-1:0] FLAGS_RST  = '0;
  localparam logic [2:0]       RATE_RST   = 3'h0;

  // AHB transfer type for a new single transfer
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> isrc_status.sv
// Interrupt source flags, enables and pending status registers
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module isrc_status
  import isrc_pkg::*;
#(
  parameter int TB_W = 16 // Timebase counter width
)
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [8:1]  OTHER_REQ,
  input  wire logic        SYNC_RX_LOAD,
  input  wire logic        SYNC_TX_LOAD,
  input  wire logic        SYNC_MASTER,
  input  wire logic        SYNC_XFER_ACTIVE,
  input  wire logic        SYNC_SELECT_N,
  input  wire logic        ASYNC_TX_LOAD,
  input  wire logic        ASYNC_TX_EMPTY,
  input  wire logic        ASYNC_BRK_IDLE_GEN,
  input  wire logic        ASYNC_RX_LOAD,
  input  wire logic        ASYNC_RX_BIT,
  input  wire logic        ASYNC_BIT_STB,
  input  wire logic        ASYNC_STOP_STB,
  input  wire logic        ASYNC_LONG_CHAR,
  input  wire logic        ASYNC_NOISE,
  input  wire logic        ASYNC_PARITY_BAD,
  input  wire logic [7:0]  KEYBOARD_REQUEST_PINS_N,
  input  wire logic        CONV_DONE,
  input  wire logic        CPU_IMASK,
  output logic             CPU_IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NFLAG-1:0]     enable_r;     // Source enables
  logic [NFLAG-1:0]     flags_r;      // Sticky source flags
  logic [NFLAG-1:0]     set_nxt;      // Hardware set events
  logic [NFLAG-1:0]     clr_nxt;      // Software clear requests
  logic [TB_RATE_W-1:0] rate_r;       // Timebase rate select
  logic [TB_W-1:0]      tb_cnt_r;     // Timebase counter chain
  logic                 tb_roll;      // Chain rollover this cycle
  logic [3:0]           ones_cnt_r;   // Consecutive ones on receive
  logic                 sel_n_q_r;    // Previous select level
  logic                 kbd_low_q_r;  // Previous any-key-low level
  logic                 kbd_low;      // Any keyboard pin low
  logic [16:1]          pend_nxt;     // Combined source requests
  logic [16:1]          pend_r;       // Registered pending flags
  logic                 wr_ph_r;      // Write data phase pending
  logic [7:0]           wr_addr_r;    // Write address latched
  logic                 addr_ok;      // Valid address phase
  logic [4:0]           idle_need;    // Ones needed for idle

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Read mux for a byte offset
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      OFS_PEND_LOW:  d[7:0] = {pend_r[6:1], 2'b00};
      OFS_PEND_MID:  d[7:0] = pend_r[14:7];
      OFS_PEND_HIGH: d[7:0] = {6'b00_0000, pend_r[16:15]};
      OFS_ENABLE:    d[NFLAG-1:0] = enable_r;
      // Done bit hidden while converter interrupts enabled
      OFS_FLAGS:     d[NFLAG-1:0] = flags_r &
                       ~(NFLAG'(enable_r[F_CONV]) << F_CONV);
      OFS_TIMEBASE:  d[TB_RATE_W-1:0] = rate_r;
      default:       d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Low bits that must all be one for a rollover
  function automatic logic [TB_W-1:0] tb_mask(
    input logic [TB_RATE_W-1:0] r);
    return TB_W'((32'h1 << (TB_BASE + int'(r))) - 32'h1);
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

  // Zero wait state, always OKAY
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end

  // Read data captured in the address phase
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
      HRDATA <= 32'h0000_0000;
    else if (addr_ok && !HWRITE)
      HRDATA <= rd_word(HADDR[7:0]);

  // Write address held for the data phase
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      wr_ph_r   <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_ph_r   <= addr_ok && HWRITE && (HADDR[31:8] == 24'h00_0000);
      wr_addr_r <= HADDR[7:0];
    end

  // Enable and rate registers; pending registers ignore writes
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      enable_r <= ENABLE_RST;
      rate_r   <= RATE_RST;
    end
    else if (wr_ph_r)
    begin
      if (wr_addr_r == OFS_ENABLE)
        enable_r <= HWDATA[NFLAG-1:0];
      if (wr_addr_r == OFS_TIMEBASE)
        rate_r <= HWDATA[TB_RATE_W-1:0];
    end

  // Software clears: one in flag register or acknowledge bit
  always_comb
  begin
    clr_nxt = '0;
    if (wr_ph_r && wr_addr_r == OFS_FLAGS)
      clr_nxt = HWDATA[NFLAG-1:0];
    if (wr_ph_r && wr_addr_r == OFS_TIMEBASE && HWDATA[TB_ACK_BIT])
      clr_nxt[F_TB] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Source event detection
  // ----------------------------------------------------------------
  // Previous levels for edge detection
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      sel_n_q_r   <= 1'b1;
      kbd_low_q_r <= 1'b0;
    end
    else
    begin
      sel_n_q_r   <= SYNC_SELECT_N;
      kbd_low_q_r <= kbd_low;
    end

  assign kbd_low   = ~&KEYBOARD_REQUEST_PINS_N;
  assign idle_need = ASYNC_LONG_CHAR ? 5'(IDLE_LONG) : 5'(IDLE_SHORT);

  // Consecutive ones on the receive line, saturating
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
      ones_cnt_r <= 4'h0;
    else if (ASYNC_BIT_STB)
    begin
      if (!ASYNC_RX_BIT)
        ones_cnt_r <= 4'h0;
      else if (ones_cnt_r != 4'hF)
        ones_cnt_r <= ones_cnt_r + 4'h1;
    end

  // Timebase counter chain
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
      tb_cnt_r <= '0;
    else
      tb_cnt_r <= tb_cnt_r + TB_W'(1);

  assign tb_roll = (tb_cnt_r & tb_mask(rate_r)) == tb_mask(rate_r);

  // Set events for every flag
  always_comb
  begin
    set_nxt = '0;
    set_nxt[F_SRX]  = SYNC_RX_LOAD;
    set_nxt[F_STX]  = SYNC_TX_LOAD;
    // master select low at any time
    set_nxt[F_MODE_FAULT_FLAG] = enable_r[F_SYNC_OVERFLOW_FLAG] &&
      (SYNC_MASTER ? !SYNC_SELECT_N
                   : (SYNC_XFER_ACTIVE && SYNC_SELECT_N && !sel_n_q_r));
    set_nxt[F_SYNC_OVERFLOW_FLAG] = SYNC_RX_LOAD && flags_r[F_SRX];
    set_nxt[F_ATX]  = ASYNC_TX_LOAD;
    // both empty, no break or idle
    set_nxt[F_TC]   = ASYNC_TX_EMPTY && !ASYNC_BRK_IDLE_GEN;
    set_nxt[F_ARX]  = ASYNC_RX_LOAD;
    set_nxt[F_IDLE] = ASYNC_BIT_STB && ASYNC_RX_BIT &&
      ({1'b0, ones_cnt_r} + 5'h01 == idle_need);
    set_nxt[F_OR]   = ASYNC_RX_LOAD && flags_r[F_ARX];
    set_nxt[F_NF]   = ASYNC_NOISE;
    set_nxt[F_FE]   = ASYNC_STOP_STB && !ASYNC_RX_BIT;
    set_nxt[F_PE]   = ASYNC_PARITY_BAD;
    set_nxt[F_KBD]  = kbd_low && !kbd_low_q_r;
    set_nxt[F_CONV] = CONV_DONE;
    set_nxt[F_TB]   = tb_roll;
  end

  // Sticky flags; a set in the clear cycle wins
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
      flags_r <= FLAGS_RST;
    else
      flags_r <= (flags_r & ~clr_nxt) | set_nxt;

  // ----------------------------------------------------------------
  // Request combination and pending status
  // ----------------------------------------------------------------
  always_comb
  begin
    pend_nxt[8:1] = OTHER_REQ;
    pend_nxt[9]   = (flags_r[F_SRX] && enable_r[F_SRX]) ||
      ((flags_r[F_MODE_FAULT_FLAG] || flags_r[F_SYNC_OVERFLOW_FLAG]) && enable_r[F_MODE_FAULT_FLAG]);
    pend_nxt[10]  = flags_r[F_STX] && enable_r[F_STX];
    pend_nxt[11]  = |(flags_r[F_PE:F_OR] & enable_r[F_PE:F_OR]);
    pend_nxt[12]  = (flags_r[F_ARX] && enable_r[F_ARX]) ||
                    (flags_r[F_IDLE] && enable_r[F_IDLE]);
    pend_nxt[13]  = (flags_r[F_ATX] && enable_r[F_ATX]) ||
                    (flags_r[F_TC] && enable_r[F_TC]);
    pend_nxt[14]  = flags_r[F_KBD] && enable_r[F_KBD];
    pend_nxt[15]  = flags_r[F_CONV] && enable_r[F_CONV];
    pend_nxt[16]  = flags_r[F_TB] && enable_r[F_TB];
  end

  // Pending flags and masked CPU request
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      pend_r  <= '0;
      CPU_IRQ <= 1'b0;
    end
    else
    begin
      pend_r  <= pend_nxt;
      CPU_IRQ <= (|pend_nxt) && !CPU_IMASK;
    end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SRX_SET: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SYNC_RX_LOAD |=> flags_r[F_SRX])
    else $error("sync receive flag not set");
  AST_STX_REQ: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SYNC_TX_LOAD && enable_r[F_STX] |=> ##1 pend_r[10])
    else $error("sync transmit request missing");
  AST_MODE_FAULT_FLAG_MST: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SYNC_MASTER && !SYNC_SELECT_N && enable_r[F_SYNC_OVERFLOW_FLAG] |=> flags_r[F_MODE_FAULT_FLAG])
    else $error("master mode fault missing");
  AST_SYNC_OVERFLOW_FLAG: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SYNC_RX_LOAD && flags_r[F_SRX] |=> flags_r[F_SYNC_OVERFLOW_FLAG])
    else $error("overflow not set");
  AST_OVERRUN: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(flags_r[F_OR]) |-> $past(ASYNC_RX_LOAD) && $past(flags_r[F_ARX]))
    else $error("overrun without cause");
  AST_FRAME: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ASYNC_STOP_STB && !ASYNC_RX_BIT |=> flags_r[F_FE])
    else $error("framing flag not set");
  AST_ERR_GATE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    pend_r[11] |-> $past(|(flags_r[F_PE:F_OR] & enable_r[F_PE:F_OR])))
    else $error("error request without enabled flag");
  AST_TB_ACK: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    flags_r[F_TB] && !tb_roll ##1 !flags_r[F_TB] |->
      $past(clr_nxt[F_TB]))
    else $error("timebase flag lost without acknowledge");
  AST_LOW_ZERO: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $past(addr_ok && !HWRITE && HADDR[7:0] == OFS_PEND_LOW) |->
      HRDATA[1:0] == 2'b00 && HRDATA[7:2] == $past(pend_r[6:1]))
    else $error("low pending register layout wrong");
  AST_MASK: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CPU_IMASK |=> !CPU_IRQ)
    else $error("request passed the global mask");
  AST_RO: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    wr_ph_r && (wr_addr_r == OFS_PEND_LOW || wr_addr_r == OFS_PEND_MID ||
      wr_addr_r == OFS_PEND_HIGH) |=> enable_r == $past(enable_r) &&
      rate_r == $past(rate_r))
    else $error("pending register write changed state");

endmodule

// >>> isrc_cpu_model.sv
// Core model: global mask bit and count of taken requests
`timescale 1ns/1ns
module isrc_cpu_model
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq,
  input  wire logic mask_req,
  output logic      imask,
  output int        taken
);
  logic irq_d_r; // Request seen last cycle

  // Global mask bit as commanded
  assign imask = mask_req;

  // Count each new request taken while unmasked
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_d_r <= 1'b0;
      taken   <= 0;
    end
    else
    begin
      irq_d_r <= irq;
      if (irq && !irq_d_r && !imask)
        taken <= taken + 1;
    end
  end
endmodule

// >>> test_interrupt_source_status.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/1ns
module test_interrupt_source_status;
  import isrc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk, rst, hsel, hwrite, hrdy, hresp, irq, imask;
  logic        mst, xfer, sel_n, txe, brk, rxb, lng, mreq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [8:1]  oreq;
  logic [7:0]  kbd;
  logic [8:0]  ev;          // Event pulses
  int          num_errors, comparisons, cyc, taken;

  isrc_status uut (.SYS_CLK(clk), .SYS_RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .OTHER_REQ(oreq), .SYNC_RX_LOAD(ev[0]),
    .SYNC_TX_LOAD(ev[1]), .SYNC_MASTER(mst), .SYNC_XFER_ACTIVE(xfer),
    .SYNC_SELECT_N(sel_n), .ASYNC_TX_LOAD(ev[2]), .ASYNC_TX_EMPTY(txe),
    .ASYNC_BRK_IDLE_GEN(brk), .ASYNC_RX_LOAD(ev[3]), .ASYNC_RX_BIT(rxb),
    .ASYNC_BIT_STB(ev[8]), .ASYNC_STOP_STB(ev[7]), .ASYNC_LONG_CHAR(lng),
    .ASYNC_NOISE(ev[4]), .ASYNC_PARITY_BAD(ev[5]),
    .KEYBOARD_REQUEST_PINS_N(kbd), .CONV_DONE(ev[6]),
    .CPU_IMASK(imask), .CPU_IRQ(irq));

  isrc_cpu_model cpu (.clk(clk), .rst(rst), .irq(irq), .mask_req(mreq),
    .imask(imask), .taken(taken));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // One single AHB transfer, waits for ready at both phases
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rc(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, r, e);
  endtask

  // Flags read with the free-running timebase bit masked off
  task automatic rf(logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, OFS_FLAGS, 32'h0, r);
    chk("flags", r & 32'h3FFF, e);
  endtask

  task automatic pulse(int i);
    @(posedge clk) ev[i] <= 1'b1;
    @(posedge clk) ev <= '0;
  endtask

  task automatic clr();
    wr(OFS_FLAGS, 32'h7FFF);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rc("enable", OFS_ENABLE, 32'h0);
    rc("unmapped", 8'h18, 32'h0);
    oreq <= 8'hA5;
    wr(OFS_PEND_LOW, 32'hFF);
    chk("hresp", hresp, 32'h0);
    rc("low", OFS_PEND_LOW, 32'h94);
    rc("mid", OFS_PEND_MID, 32'h02);
    rc("high", OFS_PEND_HIGH, 32'h0);
    oreq <= '0;
  endtask

  task automatic t_sync();
    int n;
    wr(OFS_ENABLE, 32'h1 << F_SRX);
    clr();
    n = taken;
    pulse(0);
    rc("mid", OFS_PEND_MID, 32'h04);
    chk("taken", taken, n + 1);
    mreq <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq", irq, 1'b0);
    pulse(0);
    rf(32'h9);
    mreq <= 1'b0;
  endtask

  task automatic t_fault();
    wr(OFS_ENABLE, 32'h1 << F_SYNC_OVERFLOW_FLAG);
    clr();
    mst   <= 1'b1;
    sel_n <= 1'b0;
    @(posedge clk) sel_n <= 1'b1;
    rf(32'h1 << F_MODE_FAULT_FLAG);
    mst  <= 1'b0;
    clr();
    xfer  <= 1'b1;
    sel_n <= 1'b0;
    @(posedge clk) sel_n <= 1'b1;
    @(posedge clk) xfer <= 1'b0;
    rf(32'h1 << F_MODE_FAULT_FLAG);
  endtask

  task automatic t_events();
    int fb[8] = '{F_SRX, F_STX, F_ATX, F_ARX, F_NF, F_PE, F_CONV, F_FE};
    wr(OFS_ENABLE, 32'h1 << F_STX);
    for (int i = 0; i < 8; i++)
    begin
      clr();
      pulse(i);
      rf(32'h1 << fb[i]);
    end
    clr();
    pulse(3);
    pulse(3);
    rf((32'h1 << F_ARX) | (32'h1 << F_OR));
  endtask

  task automatic t_idle();
    for (int l = 0; l < 2; l++)
    begin
      lng <= l[0];
      rxb <= 1'b0;
      pulse(8);
      rxb <= 1'b1;
      clr();
      repeat (9 + l) pulse(8);
      rf(32'h0);
      pulse(8);
      rf(32'h1 << F_IDLE);
    end
    rxb <= 1'b0;
  endtask

  task automatic t_err();
    clr();
    pulse(4);
    wr(OFS_ENABLE, 32'h1 << F_PE);
    rc("mid", OFS_PEND_MID, 32'h0);
    wr(OFS_ENABLE, 32'h1 << F_NF);
    rc("mid", OFS_PEND_MID, 32'h10);
  endtask

  task automatic t_misc();
    clr();
    txe <= 1'b1;
    brk <= 1'b1;
    rf(32'h0);
    brk <= 1'b0;
    rf(32'h1 << F_TC);
    txe <= 1'b0;
    clr();
    kbd <= 8'hF7;
    rf(32'h1 << F_KBD);
    kbd <= 8'hFF;
  endtask

  task automatic t_conv_tb();
    logic [31:0] r;
    wr(OFS_ENABLE, (32'h1 << F_CONV) | (32'h1 << F_TB));
    clr();
    r = 0;
    for (int i = 0; i < 100 && r != 32'h2; i++)
      bus(1'b0, OFS_PEND_HIGH, 32'h0, r);
    chk("high", r, 32'h2);
    // acknowledge write, well before the next rollover
    wr(OFS_TIMEBASE, 32'h8);
    pulse(6);
    rf(32'h0);
    rc("high", OFS_PEND_HIGH, 32'h1);
    wr(OFS_TIMEBASE, 32'h1);
    rc("rate", OFS_TIMEBASE, 32'h1);
  endtask

  // ------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  initial
  begin
    {hsel, hwrite, mst, xfer, txe, brk, rxb, lng, mreq} = '0;
    {htrans, haddr, hwdata, oreq, ev} = '0;
    {num_errors, comparisons, cyc} = '0;
    sel_n = 1'b1;
    kbd   = 8'hFF;
    rst   = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sync();
    t_fault();
    t_events();
    t_idle();
    t_err();
    t_misc();
    t_conv_tb();
    close_out();
  end
endmodule
